// [hw/wtr_map.svh]
/*
  register offsets, field positions, reset values and timing counts
  of the week timer alarm block. assumes a 20 MHz system clock.
*/
`ifndef WTR_MAP_SVH
`define WTR_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WTR_OFF_CTRL      8'h00
`define WTR_OFF_WEEK      8'h04
`define WTR_OFF_COMPARE   8'h08
`define WTR_OFF_PRESC     8'h0c
`define WTR_OFF_RATE      8'h10
`define WTR_OFF_SWCTRL    8'h14
`define WTR_OFF_SWCNT     8'h18
`define WTR_OFF_STATUS    8'h1c
`define WTR_OFF_MASK      8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define WTR_CTRL_RUN      0
`define WTR_CTRL_WAKE     6
`define WTR_SW_TICK_LSB   7
`define WTR_SW_NORELOAD   6
`define WTR_SW_GATE       5
`define WTR_SW_LEVEL      4
`define WTR_SW_PROBE      3
`define WTR_SWCNT_CNT_LSB 16
`define WTR_ST_WEEK       0
`define WTR_ST_SUBSEC     1
`define WTR_ST_SUBWEEK    2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define WTR_COMPARE_RST   28'hffffff
`define WTR_RUN_RST       1'h1
`define WTR_PRESC_MAX     15'h7fff
`define WTR_SRC_NONE      3'h0
`define WTR_SRC_1HZ       3'h1
`define WTR_SRC_SUBSEC    3'h2
`define WTR_SRC_32K       3'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define WTR_CLK_HZ        20000000
`define WTR_SLOW_HZ       32768
`define WTR_SLOW_CYC      (`WTR_CLK_HZ / `WTR_SLOW_HZ)

`endif

// [hw/wtr_pkg.sv]
/*
  state types of the week timer alarm block.
  assumes nothing of its surroundings.
*/
package wtr_pkg;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic [27:0] compare;
    logic [27:0] week;
    logic [14:0] presc;
    logic [3:0]  rate;
    logic [2:0]  tick_sel;
    logic        no_reload;
    logic        gate_en;
    logic        probe;
    logic        run_en;
    logic        wake_en;
    logic [8:0]  sw_load;
    logic [8:0]  sw_cnt;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        pwr_meta;
    logic        pwr_sync;
    logic        irq;
    logic        wake;
  } wtr_state_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic       pulse;
  } wtr_div_state_t;

endpackage : wtr_pkg

// [hw/wtr_tick_div.sv]
/*
  divider giving a one-cycle enable pulse every PERIOD clocks.
  assumes PERIOD between 2 and 1024.
*/
`timescale 1ns/100ps
`default_nettype none

module wtr_tick_div #(
  parameter int unsigned PERIOD = 610
) (
  input  wire logic clock,
  input  wire logic rst,
  output var  logic pulse
);
  import wtr_pkg::*;

  wtr_div_state_t st_reg;
  wtr_div_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (st_reg.cnt == 10'(PERIOD - 1)) begin
      st_next.cnt   = 10'h0;
      st_next.pulse = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 10'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;

endmodule : wtr_tick_div

`default_nettype wire

// [hw/wtr_week_timer.sv]
/*
  week compare alarm, prescaler, sub-second events and sub-week
  countdown with power-up event, behind an avalon-mm slave.
  assumes a 20 MHz clock, one battery-domain reset, and an
  asynchronous power-present pin.
*/
// Register access over Avalon-MM was decided locally.
// Overview of operation
// - week alarm and power-up event while week count >= compare value
// - compare register access completes whatever the run enable is
// - prescaler register reads live 15-bit divider, read-only
// - 4-bit sub-second rate field, zero disables sub-second events
// - rate n gives sub-second events at 2 to the n hertz
// - 3-bit tick select chooses what decrements the sub-week counter
// - on expiry reload from load value unless no-reload bit is set
// - gate enabled: power-up event only while power-present pin is high
// - gate disabled: power-present pin ignored for the power-up event
// - read-only bit 4 shows the power-present pin level
// - week count increments once per second while running
// - stopped timer holds prescaler at zero, no sub-second or sub-week ticks, week compare alarm still active
// - nonzero load write reloads sub-week counter, zero disables it
// - sub-week flag set on a tick at count one (expiry) with power-up enabled
`timescale 1ns/100ps
`default_nettype none
`include "wtr_map.svh"

module wtr_week_timer (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        system_power_present_in,
  output var  logic        irq,
  output var  logic        wake_event
);
  import wtr_pkg::*;

  wtr_state_t  st_reg;
  wtr_state_t  st_next;
  logic        tick;
  logic        ack_wr;
  logic        wrap;
  logic        subsec_hit;
  logic        sw_tick;
  logic        sw_expire;
  logic        week_ge;
  logic [14:0] presc_inc;
  logic [3:0]  bit_sel;
  logic [2:0]  st_set;
  logic [2:0]  st_clr;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // 32.768 kHz enable
  // ----------------------------------------
  wtr_tick_div #(
    .PERIOD (`WTR_SLOW_CYC)
  ) u_div (
    .clock (clock),
    .rst   (rst),
    .pulse (tick)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      `WTR_OFF_CTRL: begin
        rd_mux[`WTR_CTRL_RUN]  = st_reg.run_en;
        rd_mux[`WTR_CTRL_WAKE] = st_reg.wake_en;
      end
      `WTR_OFF_WEEK:    rd_mux[27:0] = st_reg.week;
      `WTR_OFF_COMPARE: rd_mux[27:0] = st_reg.compare;
      `WTR_OFF_PRESC:   rd_mux[14:0] = st_reg.presc;
      `WTR_OFF_RATE:    rd_mux[3:0]  = st_reg.rate;
      `WTR_OFF_SWCTRL: begin
        rd_mux[`WTR_SW_TICK_LSB +: 3] = st_reg.tick_sel;
        rd_mux[`WTR_SW_NORELOAD]      = st_reg.no_reload;
        rd_mux[`WTR_SW_GATE]          = st_reg.gate_en;
        rd_mux[`WTR_SW_LEVEL]         = st_reg.pwr_sync;
        rd_mux[`WTR_SW_PROBE]         = st_reg.probe;
      end
      `WTR_OFF_SWCNT: begin
        rd_mux[`WTR_SWCNT_CNT_LSB +: 9] = st_reg.sw_cnt;
        rd_mux[8:0]                     = st_reg.sw_load;
      end
      `WTR_OFF_STATUS:  rd_mux[2:0] = st_reg.status;
      `WTR_OFF_MASK:    rd_mux[2:0] = st_reg.mask;
      default:          rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next    = st_reg;
    ack_wr     = !st_reg.waitreq && avs_write;
    presc_inc  = st_reg.presc + 15'h1;
    bit_sel    = 4'hf - st_reg.rate;
    wrap       = st_reg.run_en && tick && (st_reg.presc == `WTR_PRESC_MAX);
    week_ge    = st_reg.week >= st_reg.compare;
    st_clr     = 3'h0;

    // one wait state, then the answer
    st_next.waitreq = !(st_reg.waitreq && (avs_read || avs_write));
    if (st_reg.waitreq && avs_read) begin
      st_next.rdata = rd_mux;
    end

    // pin synchroniser
    st_next.pwr_meta = system_power_present_in;
    st_next.pwr_sync = st_reg.pwr_meta;

    if (!st_reg.run_en) begin
      st_next.presc = 15'h0;
    end else if (tick) begin
      st_next.presc = presc_inc;
    end

    if (wrap) begin
      st_next.week = st_reg.week + 28'h1;
    end

    subsec_hit = st_reg.run_en && tick && (st_reg.rate != 4'h0) &&
                 (presc_inc[bit_sel] != st_reg.presc[bit_sel]);

    case (st_reg.tick_sel)
      `WTR_SRC_1HZ:    sw_tick = wrap;
      `WTR_SRC_SUBSEC: sw_tick = subsec_hit;
      `WTR_SRC_32K:    sw_tick = st_reg.run_en && tick;
      default:         sw_tick = 1'b0;
    endcase

    sw_expire = sw_tick && (st_reg.sw_cnt == 9'h1);
    if (sw_tick && (st_reg.sw_cnt != 9'h0)) begin
      if (sw_expire) begin
        st_next.sw_cnt = st_reg.no_reload ? 9'h0 : st_reg.sw_load;
      end else begin
        st_next.sw_cnt = st_reg.sw_cnt - 9'h1;
      end
    end

    // register writes at the acknowledge edge
    if (ack_wr) begin
      case (avs_address)
        `WTR_OFF_CTRL: begin
          st_next.run_en  = avs_writedata[`WTR_CTRL_RUN];
          st_next.wake_en = avs_writedata[`WTR_CTRL_WAKE];
        end
        `WTR_OFF_WEEK:    st_next.week    = avs_writedata[27:0];
        `WTR_OFF_COMPARE: st_next.compare = avs_writedata[27:0];
        `WTR_OFF_RATE:    st_next.rate    = avs_writedata[3:0];
        `WTR_OFF_SWCTRL: begin
          st_next.tick_sel  = avs_writedata[`WTR_SW_TICK_LSB +: 3];
          st_next.no_reload = avs_writedata[`WTR_SW_NORELOAD];
          st_next.gate_en   = avs_writedata[`WTR_SW_GATE];
          st_next.probe     = avs_writedata[`WTR_SW_PROBE];
        end
        `WTR_OFF_SWCNT: begin
          st_next.sw_load = avs_writedata[8:0];
          st_next.sw_cnt  = avs_writedata[8:0];
        end
        `WTR_OFF_STATUS:  st_clr       = avs_writedata[2:0];
        `WTR_OFF_MASK:    st_next.mask = avs_writedata[2:0];
        default:          st_clr       = 3'h0;
      endcase
    end

    // set wins over a same-cycle clear
    st_set                 = 3'h0;
    st_set[`WTR_ST_WEEK]   = week_ge;
    st_set[`WTR_ST_SUBSEC] = subsec_hit;
    st_set[`WTR_ST_SUBWEEK] = sw_expire && st_reg.wake_en;
    st_next.status = (st_reg.status & ~st_clr) | st_set;
    st_next.irq    = |(st_next.status & st_next.mask);

    st_next.wake = st_reg.wake_en &&
                   (week_ge || st_reg.status[`WTR_ST_SUBWEEK]) &&
                   (!st_reg.gate_en || st_reg.pwr_sync);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.waitreq <= 1'b1;
      st_reg.compare <= `WTR_COMPARE_RST;
      st_reg.run_en  <= `WTR_RUN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign irq             = st_reg.irq;
  assign wake_event      = st_reg.wake;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_WEEK_ALARM: assert property (
    st_reg.week >= st_reg.compare |=> st_reg.status[`WTR_ST_WEEK])
    else $error("week alarm not set at compare match");

  AST_ACCESS_DONE: assert property (
    st_reg.waitreq && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered in one wait state");

  AST_PRESC_READ: assert property (
    !st_reg.waitreq && avs_read && avs_address == `WTR_OFF_PRESC && $past(avs_read)
    |-> avs_readdata == {17'h0, $past(st_reg.presc)})
    else $error("prescaler read does not match divider");

  AST_SUBSEC_OFF: assert property (
    st_reg.rate == 4'h0 |=> !(st_reg.status[`WTR_ST_SUBSEC] && !$past(st_reg.status[`WTR_ST_SUBSEC])))
    else $error("sub-second event with rate zero");

  AST_SUBSEC_FAST: assert property (
    st_reg.rate == 4'hf && st_reg.run_en && tick |=> st_reg.status[`WTR_ST_SUBSEC])
    else $error("fastest rate missed a tick");

  AST_RELOAD: assert property (
    sw_expire && !st_reg.no_reload && !ack_wr |=> st_reg.sw_cnt == $past(st_reg.sw_load))
    else $error("sub-week counter not reloaded");

  AST_NO_RELOAD: assert property (
    sw_expire && st_reg.no_reload && !ack_wr |=> st_reg.sw_cnt == 9'h0)
    else $error("sub-week counter reloaded while inhibited");

  AST_GATE_OFF: assert property (
    st_reg.gate_en && !st_reg.pwr_sync |=> !wake_event)
    else $error("power-up event while power absent");

  AST_GATE_IGNORED: assert property (
    !st_reg.gate_en && st_reg.wake_en && week_ge |=> wake_event)
    else $error("power-up event missing with gate off");

  AST_WEEK_STEP: assert property (
    wrap && !ack_wr |=> st_reg.week == $past(st_reg.week) + 28'h1 && st_reg.presc == 15'h0)
    else $error("week count did not step on wrap");

  AST_STOP_HOLD: assert property (
    !st_reg.run_en [*2] |-> st_reg.presc == 15'h0)
    else $error("prescaler moved while stopped");

  AST_SW_FLAG: assert property (
    sw_expire && st_reg.wake_en |=> st_reg.status[`WTR_ST_SUBWEEK] &&
                                    (irq || !st_reg.mask[`WTR_ST_SUBWEEK]))
    else $error("sub-week flag not set on expiry");

  AST_SRC_NONE: assert property (
    st_reg.tick_sel == `WTR_SRC_NONE && !ack_wr |=> st_reg.sw_cnt == $past(st_reg.sw_cnt))
    else $error("sub-week counter moved with no source");

  AST_PIN_LEVEL: assert property (
    st_reg.waitreq && avs_read && avs_address == `WTR_OFF_SWCTRL
    |=> avs_readdata[`WTR_SW_LEVEL] == $past(system_power_present_in, 3))
    else $error("pin level bit does not follow the pin");

  AST_LOAD_WRITE: assert property (
    ack_wr && avs_address == `WTR_OFF_SWCNT
    |=> st_reg.sw_cnt == $past(avs_writedata[8:0]) &&
        st_reg.sw_load == $past(avs_writedata[8:0]))
    else $error("load write did not set the sub-week counter");

  AST_SWCTRL_RSVD: assert property (
    st_reg.waitreq && avs_read && avs_address == `WTR_OFF_SWCTRL
    |=> avs_readdata[31:10] == 22'h0 && avs_readdata[2:0] == 3'h0)
    else $error("reserved sub-week control bits not zero");

  AST_WAKE_OFF: assert property (
    !st_reg.wake_en |=> !wake_event)
    else $error("power-up event with output disabled");

  COV_SUBSEC: cover property (subsec_hit);
  COV_RELOAD: cover property (sw_expire && !st_reg.no_reload);
  COV_WAKE:   cover property (!wake_event ##1 wake_event);
  COV_READ:   cover property (avs_read && !avs_waitrequest);
  COV_GATED:  cover property (st_reg.gate_en && st_reg.pwr_sync && wake_event);

endmodule : wtr_week_timer

`default_nettype wire

// [testbench/tb_top.sv]
/*
  self-checking bench of the week timer alarm block.
  assumes wtr_week_timer with its avalon-mm slave and a 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import wtr_pkg::*;

  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  logic        clock;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        system_power_present_in;
  logic        irq;
  logic        wake_event;
  int          err_count;
  int          cmp_count;
  int          cycles;
  logic [31:0] rd;

  wtr_week_timer dut (
    .clock                   (clock),
    .rst                     (rst),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .system_power_present_in (system_power_present_in),
    .irq                     (irq),
    .wake_event              (wake_event)
  );

  initial clock = 1'b0;
  always #25 clock = ~clock;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // ceiling far above the ~9000 cycles the scenarios need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [7:0] a, input logic is_wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= is_wr;
    avs_read      <= ~is_wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check(32'(n), 32'h2);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h08, 32'h0ffffff);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h09, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'hf);
    // probe bit left clear, software never sets it
    wr(8'h14, 32'hfffffff7);
    rd_chk(8'h14, 32'h3e0);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h0);
  endtask : t_reset

  task automatic t_compare;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'hffffffff);
    rd_chk(8'h08, 32'h0fffffff);
    rd_chk(8'h0c, 32'h0);
    wr(8'h0c, 32'h1234);
    rd_chk(8'h0c, 32'h0);
  endtask : t_compare

  task automatic t_alarm;
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h10);
    wr(8'h1c, 32'h7);
    rd_chk(8'h1c, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(8'h20, 32'h1);
    wait_clk(3);
    check({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h11);
    wr(8'h1c, 32'h1);
    rd_chk(8'h1c, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h08, 32'h0f);
    rd_chk(8'h1c, 32'h1);
    wr(8'h20, 32'h0);
  endtask : t_alarm

  task automatic t_wake;
    wr(8'h08, 32'h10);
    wr(8'h00, 32'h40);
    wait_clk(4);
    check({31'h0, wake_event}, 32'h1);
    wr(8'h14, 32'h20);
    wait_clk(4);
    check({31'h0, wake_event}, 32'h0);
    rd_chk(8'h14, 32'h20);
    system_power_present_in <= 1'b1;
    wait_clk(4);
    check({31'h0, wake_event}, 32'h1);
    rd_chk(8'h14, 32'h30);
    system_power_present_in <= 1'b0;
    wr(8'h14, 32'h0);
    wait_clk(4);
    check({31'h0, wake_event}, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0fffffff);
    wr(8'h1c, 32'h7);
    wait_clk(4);
    check({31'h0, wake_event}, 32'h0);
  endtask : t_wake

  task automatic t_subsec;
    wr(8'h00, 32'h1);
    wr(8'h10, 32'hf);
    wr(8'h1c, 32'h7);
    wait_clk(1300);
    rd_chk(8'h1c, 32'h2);
    // a landed write would leave the divider near 7ff0
    wr(8'h0c, 32'h7ff0);
    bus(8'h0c, 1'b0, 32'h0);
    check({31'h0, rd != 0 && rd < 32'h20}, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h1c, 32'h7);
    wait_clk(1300);
    rd_chk(8'h1c, 32'h0);
    // divider has counted several ticks by now
    wr(8'h00, 32'h0);
    rd_chk(8'h0c, 32'h0);
  endtask : t_subsec

  task automatic t_subweek;
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h2);
    wait_clk(1400);
    rd_chk(8'h18, 32'h00020002);
    wr(8'h14, 32'h180);
    wr(8'h00, 32'h41);
    wait_clk(1400);
    rd_chk(8'h1c, 32'h4);
    bus(8'h18, 1'b0, 32'h0);
    check({31'h0, rd[24:16] != 9'h0}, 32'h1);
    check({31'h0, wake_event}, 32'h1);
    wr(8'h14, 32'h1c0);
    wr(8'h18, 32'h2);
    wait_clk(1400);
    rd_chk(8'h18, 32'h00000002);
    wr(8'h18, 32'h3);
    wr(8'h18, 32'h0);
    wait_clk(1400);
    rd_chk(8'h18, 32'h0);
  endtask : t_subweek

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst                     = 1'b1;
    avs_address             = 8'h0;
    avs_read                = 1'b0;
    avs_write               = 1'b0;
    avs_writedata           = 32'h0;
    system_power_present_in = 1'b0;
    err_count               = 0;
    cmp_count               = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_compare();
    t_alarm();
    t_wake();
    t_subsec();
    t_subweek();
    end_of_test();
  end

endmodule : tb_top

`default_nettype wire
